// ---- acc_conv_ctrl.sv ----
// converter control: registers, prescaler, triggering, sequencing and result holding
// assumes a wishbone master on CLK_SYS and an analog core that delivers a 10-bit sample
// Function
// - auto-trigger bit selects triggered or single mode
// - flag sets when result registers updated
// - flag cleared by vector or write one
// - interrupt request only while enable set
// - prescaler divides clock by 2 to 128
// - disable bit blocks sleep-entry auto start
// - single-shot blocks sync triggers until high read
// - trigger on rising edge of event flag
// - 4-bit source field, codes above 8 reserved
// - low read freezes results until high read
// - left adjust puts bits 9:2 in high
// - disable bit forces port input zero
// - amplifier samples on sync clock falling edge
// - sync from stage events or clock/8
// - user start takes 13 or 14 cycles
// - amplified conversion blocks other channel starts
// - amplifier change in sample phase restarts conversion
// - auto amplified start at next amp event
// - amplified auto mode never free-runs
// - start bit self-clears, writing zero ignored
// - disable during conversion applies at end
// - amp select 00 clock/8, 01/11 stage events
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int DATA_W = 10
)
(
  input  wire logic               CLK_SYS,
  input  wire logic               RST,
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [7:0]         WB_ADR_I,
  input  wire logic [3:0]         WB_SEL_I,
  input  wire logic [31:0]        WB_DAT_I,
  output logic      [31:0]        WB_DAT_O,
  output logic                    WB_ACK_O,
  input  wire logic [8:0]         TRIG_EVENTS,
  input  wire logic               IRQ_VECTOR_ACK,
  input  wire logic               SLEEP_ENTRY,
  input  wire logic [DATA_W-1:0]  CORE_RESULT,
  input  wire logic               AMP_OUT_CHANGED,
  input  wire logic [10:0]        PORT_PIN_IN,
  output logic [10:0]             PORT_PIN_OUT,
  output logic [10:0]             INPUT_BUF_OFF,
  output logic                    CONV_IRQ,
  output logic                    CONV_CLK,
  output logic                    AMP_SYNC_CLK,
  output logic                    CORE_SAMPLE,
  output logic                    CONVERTING,
  output logic                    HIGH_SPEED,
  output logic [3:0]              CHANNEL
);

  // tag helper: rising edge of a level
  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction

  logic [7:0]       ctrl_a_reg;
  logic [7:0]       ctrl_b_reg;
  logic [7:0]       chan_reg;
  logic [7:0]       amp_reg;
  logic [7:0]       dis0_reg;
  logic [2:0]       dis1_reg;
  logic [DATA_W-1:0] result_reg;
  logic             locked_reg;
  logic             ss_block_reg;
  logic             enable_pend_reg;
  logic [8:0]       events_reg;
  logic [6:0]       presc_reg;
  logic             conv_tick;
  logic [2:0]       amp_div_reg;
  logic [4:0]       cycle_reg;
  logic [4:0]       cycle_target_reg;
  logic             wait_amp_reg;
  logic             ext_amp_prev_reg;
  acc_state_type    state_reg;
  acc_state_type    state_next;
  acc_bus_req_type  req;
  logic             wr;
  logic             rd;
  logic             start_sw;
  logic             trig_hit;
  logic             start_any;
  logic             conv_done;
  logic             amp_event;
  logic             is_amp;
  logic [7:0]       res_low;
  logic [7:0]       res_high;
  logic [6:0]       div_mask;

  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I, dat: WB_DAT_I[7:0]};
  // one access per handshake: ack drops in the cycle after it rises
  assign wr = req.cyc & req.stb & ~WB_ACK_O & req.we & WB_SEL_I[0];
  assign rd = req.cyc & req.stb & ~WB_ACK_O & ~req.we;
  assign is_amp = (chan_reg[3:0] == CHAN_AMP);

  // bus acknowledge, one cycle after the request
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      WB_ACK_O <= 1'b0;
    else
      WB_ACK_O <= req.cyc & req.stb & ~WB_ACK_O;
  end

  // result justification
  always_comb
  begin
    if (chan_reg[CH_LEFT])
    begin
      res_high = result_reg[9:2];
      res_low  = {result_reg[1:0], 6'h00};
    end
    else
    begin
      res_high = {6'h00, result_reg[9:8]};
      res_low  = result_reg[7:0];
    end
  end

  // read data, unmapped addresses read zero
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      WB_DAT_O <= 32'h00000000;
    else if (rd)
    begin
      case (req.adr)
        OFF_CTRL_A:   WB_DAT_O <= {24'h000000, ctrl_a_reg};
        OFF_CTRL_B:   WB_DAT_O <= {24'h000000, ctrl_b_reg[7:6], 1'b0, ctrl_b_reg[4:0]};
        OFF_RES_LOW:  WB_DAT_O <= {24'h000000, res_low};
        OFF_RES_HIGH: WB_DAT_O <= {24'h000000, res_high};
        OFF_DIS_0:    WB_DAT_O <= {24'h000000, dis0_reg};
        OFF_DIS_1:    WB_DAT_O <= {29'h00000000, dis1_reg};
        OFF_CHAN:     WB_DAT_O <= {24'h000000, chan_reg[7:5], 1'b0, chan_reg[3:0]};
        OFF_AMP:      WB_DAT_O <= {30'h00000000, amp_reg[1:0]};
        default:      WB_DAT_O <= 32'h00000000;
      endcase
    end
  end

  // plain configuration registers
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ctrl_b_reg <= RST_CTRL_B;
      dis0_reg   <= RST_DIS;
      dis1_reg   <= RST_DIS[2:0];
      chan_reg   <= RST_CHAN;
      amp_reg    <= RST_AMP;
    end
    else if (wr)
    begin
      if (req.adr == OFF_CTRL_B)
        ctrl_b_reg <= req.dat;
      if (req.adr == OFF_DIS_0)
        dis0_reg <= req.dat;
      if (req.adr == OFF_DIS_1)
        dis1_reg <= req.dat[2:0];
      if (req.adr == OFF_CHAN)
        chan_reg <= req.dat;
      if (req.adr == OFF_AMP)
        amp_reg <= req.dat;
    end
  end

  // prescaler: free counter, tick when masked bits are all ones
  always_comb
  begin
    case (ctrl_a_reg[2:0])
      3'h0, 3'h1: div_mask = 7'h01;
      3'h2:       div_mask = 7'h03;
      3'h3:       div_mask = 7'h07;
      3'h4:       div_mask = 7'h0f;
      3'h5:       div_mask = 7'h1f;
      3'h6:       div_mask = 7'h3f;
      default:    div_mask = 7'h7f;
    endcase
  end
  assign conv_tick = ((presc_reg & div_mask) == div_mask);

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      presc_reg <= 7'h00;
    else
      presc_reg <= presc_reg + 7'h01;
  end

  // amplifier sync clock: converter clock divided by 8, low for the first half
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      amp_div_reg <= 3'h0;
    else if (conv_tick)
      amp_div_reg <= amp_div_reg + 3'h1;
  end

  // event flags captured for edge detection
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      events_reg       <= 9'h000;
      ext_amp_prev_reg <= 1'b0;
    end
    else
    begin
      events_reg       <= TRIG_EVENTS;
      ext_amp_prev_reg <= (amp_reg[1:0] == AMP_TRG_R) ? TRIG_EVENTS[TRG_STAGE_R] : TRIG_EVENTS[TRG_STAGE_2];
    end
  end

  // amplifier event: falling edge of internal clock, or rising stage event
  always_comb
  begin
    case (amp_reg[1:0])
      AMP_TRG_DIV: amp_event = conv_tick & (amp_div_reg == 3'h7);
      AMP_TRG_R:   amp_event = rise(TRIG_EVENTS[TRG_STAGE_R], ext_amp_prev_reg);
      AMP_TRG_2:   amp_event = rise(TRIG_EVENTS[TRG_STAGE_2], ext_amp_prev_reg);
      default:     amp_event = 1'b0;
    endcase
  end

  // trigger selection
  always_comb
  begin
    trig_hit = 1'b0;
    if (ctrl_a_reg[A_AUTO] && ctrl_b_reg[3:0] != TRG_FREE && ctrl_b_reg[3:0] <= TRG_LAST)
      trig_hit = rise(TRIG_EVENTS[ctrl_b_reg[3:0]], events_reg[ctrl_b_reg[3:0]]);
    if ((ctrl_b_reg[3:0] == TRG_STAGE_R || ctrl_b_reg[3:0] == TRG_STAGE_2) && ss_block_reg)
      trig_hit = 1'b0;
  end

  // software start, free running, triggered start, sleep entry start
  assign start_sw  = ctrl_a_reg[A_START] & ctrl_a_reg[A_ENABLE];
  always_comb
  begin
    start_any = 1'b0;
    if (ctrl_a_reg[A_ENABLE])
    begin
      if (ctrl_a_reg[A_AUTO])
        start_any = trig_hit | (ctrl_b_reg[3:0] == TRG_FREE & ~is_amp);
      start_any = start_any | start_sw | (SLEEP_ENTRY & ~ctrl_b_reg[B_NOSLEEP]);
    end
  end

  assign conv_done = (state_reg == ST_CONV) & conv_tick & (cycle_reg == cycle_target_reg);

  // sequencer
  always_comb
  begin
    case (state_reg)
      ST_IDLE: state_next = start_any ? (is_amp ? ST_WAIT : ST_CONV) : ST_IDLE;
      ST_WAIT: state_next = ((start_sw | ~ctrl_a_reg[A_AUTO]) || amp_event) ? ST_CONV : ST_WAIT;
      ST_CONV: state_next = conv_done ? ST_IDLE : ST_CONV;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      state_reg        <= ST_IDLE;
      cycle_reg        <= 5'h00;
      cycle_target_reg <= 5'h00;
      wait_amp_reg     <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg != ST_CONV && state_next == ST_CONV)
      begin
        cycle_reg <= 5'h00;
        // amplified channel start while sync clock high costs a synchronisation cycle
        cycle_target_reg <= (is_amp && amp_div_reg[2]) ? 5'(CONV_CYCLES_SYNC) : 5'(CONV_CYCLES);
      end
      else if (state_reg == ST_CONV && is_amp && AMP_OUT_CHANGED && cycle_reg < 5'h02)
        cycle_reg <= 5'h00;
      else if (state_reg == ST_CONV && conv_tick)
        cycle_reg <= cycle_reg + 5'h01;
      wait_amp_reg <= (state_reg == ST_WAIT);
    end
  end

  // control a: start self-clears, flag set wins over clear, enable deferred
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ctrl_a_reg      <= RST_CTRL_A;
      enable_pend_reg <= 1'b0;
    end
    else
    begin
      if (wr && req.adr == OFF_CTRL_A)
      begin
        ctrl_a_reg[A_AUTO]   <= req.dat[A_AUTO];
        ctrl_a_reg[A_IRQ_EN] <= req.dat[A_IRQ_EN];
        ctrl_a_reg[2:0]      <= req.dat[2:0];
        if (req.dat[A_START])
          ctrl_a_reg[A_START] <= 1'b1;
        if (req.dat[A_FLAG])
          ctrl_a_reg[A_FLAG] <= 1'b0;
        if (state_reg != ST_IDLE && !req.dat[A_ENABLE])
          enable_pend_reg <= 1'b1;
        else
        begin
          ctrl_a_reg[A_ENABLE] <= req.dat[A_ENABLE];
          enable_pend_reg      <= 1'b0;
        end
      end
      if (IRQ_VECTOR_ACK)
        ctrl_a_reg[A_FLAG] <= 1'b0;
      if (conv_done)
      begin
        ctrl_a_reg[A_START] <= 1'b0;
        ctrl_a_reg[A_FLAG]  <= 1'b1;
        if (enable_pend_reg)
        begin
          ctrl_a_reg[A_ENABLE] <= 1'b0;
          enable_pend_reg      <= 1'b0;
        end
      end
    end
  end

  // result holding and single-shot block
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      result_reg   <= '0;
      locked_reg   <= 1'b0;
      ss_block_reg <= 1'b0;
    end
    else
    begin
      if (conv_done && !locked_reg)
        result_reg <= CORE_RESULT;
      if (rd && req.adr == OFF_RES_LOW)
        locked_reg <= 1'b1;
      else if (rd && req.adr == OFF_RES_HIGH)
        locked_reg <= 1'b0;
      if (rd && req.adr == OFF_RES_HIGH)
        ss_block_reg <= 1'b0;
      else if (trig_hit && ctrl_b_reg[B_SINGLE])
        ss_block_reg <= 1'b1;
    end
  end

  // registered outputs
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      CONV_IRQ      <= 1'b0;
      CONV_CLK      <= 1'b0;
      AMP_SYNC_CLK  <= 1'b0;
      CORE_SAMPLE   <= 1'b0;
      CONVERTING    <= 1'b0;
      HIGH_SPEED    <= 1'b0;
      CHANNEL       <= 4'h0;
      PORT_PIN_OUT  <= 11'h000;
      INPUT_BUF_OFF <= 11'h000;
    end
    else
    begin
      CONV_IRQ      <= ctrl_a_reg[A_FLAG] & ctrl_a_reg[A_IRQ_EN];
      CONV_CLK      <= conv_tick;
      AMP_SYNC_CLK  <= amp_div_reg[2];
      CORE_SAMPLE   <= wait_amp_reg ? 1'b0 : amp_event;
      CONVERTING    <= (state_next == ST_CONV);
      HIGH_SPEED    <= ctrl_b_reg[B_HSPEED];
      CHANNEL       <= chan_reg[3:0];
      INPUT_BUF_OFF <= {dis1_reg, dis0_reg};
      PORT_PIN_OUT  <= PORT_PIN_IN & ~{dis1_reg, dis0_reg};
    end
  end

endmodule
`default_nettype wire

// ---- acc_conv_ctrl_chk.sv ----
// concurrent checks on the converter control block ports
// assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module acc_conv_ctrl_chk
  import acc_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic        WB_ACK_O,
  input wire logic [10:0] PORT_PIN_IN,
  input wire logic [10:0] PORT_PIN_OUT,
  input wire logic [10:0] INPUT_BUF_OFF,
  input wire logic        CONV_IRQ,
  input wire logic        CONV_CLK,
  input wire logic        CORE_SAMPLE,
  input wire logic        CONVERTING,
  input wire logic        HIGH_SPEED,
  input wire logic        AMP_OUT_CHANGED
);
  logic [7:0] tick_cnt_reg;
  logic       disturbed_reg;

  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  // converter ticks inside one conversion; a disturbed one may restart, so it is exempt
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST || !CONVERTING)
    begin
      tick_cnt_reg  <= 8'h00;
      disturbed_reg <= 1'b0;
    end
    else
    begin
      tick_cnt_reg  <= tick_cnt_reg + {7'h00, CONV_CLK};
      disturbed_reg <= disturbed_reg | AMP_OUT_CHANGED;
    end

  AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered in the next cycle");
  AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("answer longer than one cycle");
  AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I) && $past(WB_STB_I))
    else $error("answer without request");
  AST_HSPEED_WRITE: assert property ($changed(HIGH_SPEED) |-> $past(WB_STB_I) && $past(WB_WE_I)
    && $past(WB_ADR_I) == OFF_CTRL_B)
    else $error("high speed output moved without a control b write");
  AST_TICK_GAP: assert property (CONV_CLK |=> !CONV_CLK)
    else $error("converter tick on two cycles in a row");
  AST_PIN_MASK: assert property (!$past(RST) |-> PORT_PIN_OUT == ($past(PORT_PIN_IN) & ~INPUT_BUF_OFF))
    else $error("port input not masked by disable bits");
  // tolerance of one tick either side covers where the first and last tick fall
  AST_CONV_LEN: assert property ($fell(CONVERTING) && !disturbed_reg |-> tick_cnt_reg >= 8'd12
    && tick_cnt_reg <= 8'd15)
    else $error("conversion length outside 13 to 14 ticks");
  AST_IRQ_CAUSE: assert property ($rose(CONV_IRQ) |-> $past(CONVERTING, 1) || $past(CONVERTING, 2)
    || $past(CONVERTING, 3) || $past(WB_ACK_O, 1) || $past(WB_ACK_O, 2))
    else $error("interrupt rose without conversion end or enable write");
  AST_SAMPLE_ONE: assert property (CORE_SAMPLE |=> !CORE_SAMPLE)
    else $error("sample strobe longer than one cycle");
endmodule
bind acc_conv_ctrl acc_conv_ctrl_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O), .PORT_PIN_IN(PORT_PIN_IN),
  .PORT_PIN_OUT(PORT_PIN_OUT), .INPUT_BUF_OFF(INPUT_BUF_OFF), .CONV_IRQ(CONV_IRQ), .CONV_CLK(CONV_CLK),
  .CORE_SAMPLE(CORE_SAMPLE), .CONVERTING(CONVERTING), .HIGH_SPEED(HIGH_SPEED), .AMP_OUT_CHANGED(AMP_OUT_CHANGED));
`default_nettype wire

// ---- acc_conv_ctrl_test.sv ----
// self-checking bench for the converter control block
// assumes the core model beside the block and the bound checker
`timescale 1ns/1ns
`default_nettype none
module acc_conv_ctrl_test
  import acc_pkg::*;
;
  logic        clk_sys, rst, cyc, stb, we, vec, sleep, disturb, ack, irq, cclk, aclk, samp, conv, hs, chg;
  logic [7:0]  adr;
  logic [3:0]  sel, chan;
  logic [31:0] wdat, rdat;
  logic [8:0]  ev;
  logic [9:0]  res, core_val, core_res;
  logic [10:0] pin_in, pin_out, buf_off, dis;
  logic [15:0] seed;
  logic [7:0]  expq[$];
  logic [7:0]  offs[7] = '{OFF_CTRL_A, OFF_CTRL_B, OFF_RES_LOW, OFF_RES_HIGH, OFF_DIS_0, OFF_DIS_1, 8'h20};
  int          error_cnt = 0;
  int          comparisons = 0;

  acc_conv_ctrl dut (.CLK_SYS(clk_sys), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .TRIG_EVENTS(ev), .IRQ_VECTOR_ACK(vec),
    .SLEEP_ENTRY(sleep), .CORE_RESULT(core_res), .AMP_OUT_CHANGED(chg), .PORT_PIN_IN(pin_in),
    .PORT_PIN_OUT(pin_out), .INPUT_BUF_OFF(buf_off), .CONV_IRQ(irq), .CONV_CLK(cclk), .AMP_SYNC_CLK(aclk),
    .CORE_SAMPLE(samp), .CONVERTING(conv), .HIGH_SPEED(hs), .CHANNEL(chan));
  acc_core_model core (.clk_sys(clk_sys), .rst(rst), .converting(conv), .core_sample(samp),
    .sample_value(core_val), .disturb(disturb), .core_result(core_res), .amp_out_changed(chg));

  // free-running 125 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // pseudo-random source for data and pin patterns
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; a read leaves its expected byte for the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    if (!w)
      expq.push_back(e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    // no cycle count is assumed here: only the hang guard ends a missing answer
    do
      @(posedge clk_sys);
    while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask

  // edges until the next converter tick
  task automatic tick(output int n);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (cclk !== 1'b1 && n < 300);
  endtask

  // a completion is awaited under a bound; an absence is judged after a fixed quiet span
  task automatic wait_irq(input logic e, input int lim);
    int n;
    n = 0;
    if (e)
      while (irq !== 1'b1 && n < lim)
      begin
        @(posedge clk_sys);
        n++;
      end
    else
      repeat (lim) @(posedge clk_sys);
    chk(32'(irq), 32'(e));
  endtask

  // one-cycle strobe: 0..8 trigger events, 9 vector taken, 10 sleep entry
  task automatic kick(input int k);
    if (k < 9)
      ev[k] <= 1'b1;
    else if (k == 9)
      vec <= 1'b1;
    else
      sleep <= 1'b1;
    @(posedge clk_sys);
    ev <= 9'h000;
    vec <= 1'b0;
    sleep <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // read answers are judged at the edge where the answer is sampled
  always @(posedge clk_sys)
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
      chk(rdat, {24'h000000, expq.pop_front()});

  // hang guard well beyond the expected run length
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end

  // main sequence
  initial
  begin
    int n;
    time t0;
    {rst, cyc, stb, we, vec, sleep, disturb} = 7'b1000000;
    {adr, wdat, ev, pin_in, core_val} = '0;
    sel = 4'hf;
    seed = 16'h6d3e;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    bus(1'b1, 8'h20, 8'hff, 8'h00);
    foreach (offs[i])
      bus(1'b0, offs[i], 8'h00, 8'h00);
    seed = lfsr(seed);
    dis = {seed[10:8], seed[7:0]};
    bus(1'b1, OFF_DIS_0, dis[7:0], 8'h00);
    bus(1'b1, OFF_DIS_1, {5'h00, dis[10:8]}, 8'h00);
    sel <= 4'he;
    bus(1'b1, OFF_DIS_0, ~dis[7:0], 8'h00);
    sel <= 4'hf;
    bus(1'b0, OFF_DIS_0, 8'h00, dis[7:0]);
    seed = lfsr(seed);
    pin_in <= seed[10:0];
    repeat (3) @(posedge clk_sys);
    chk(32'(pin_out), 32'(pin_in & ~dis));
    chk(32'(buf_off), 32'(dis));
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, OFF_CTRL_A, 8'h80 | 8'(c), 8'h00);
      tick(n);
      tick(n);
      tick(n);
      chk(32'(n), (c < 2) ? 32'h2 : 32'h1 << c);
    end
    // sync clock period at divide-by-128, measured between two rising edges of an 8 ns clock
    @(posedge aclk);
    t0 = $time;
    @(posedge aclk);
    chk(32'(($time - t0) / 8), 32'(AMP_DIV * 128));
    bus(1'b1, OFF_CTRL_B, 8'h80, 8'h00);
    bus(1'b0, OFF_CTRL_B, 8'h00, 8'h80);
    chk(32'(hs), 32'h1);
    bus(1'b1, OFF_CTRL_B, 8'h00, 8'h00);
    chk(32'(hs), 32'h0);
    // every converter clock used below is above 200kHz, so high speed stays selected
    bus(1'b1, OFF_CTRL_B, 8'h80, 8'h00);
    seed = lfsr(seed);
    res = seed[9:0];
    core_val <= res;
    bus(1'b1, OFF_CTRL_A, 8'hc8, 8'h00);
    wait_irq(1'b1, 2000);
    bus(1'b0, OFF_CTRL_A, 8'h00, 8'h98);
    bus(1'b0, OFF_RES_LOW, 8'h00, res[7:0]);
    bus(1'b0, OFF_RES_HIGH, 8'h00, {6'h00, res[9:8]});
    bus(1'b1, OFF_CHAN, 8'h20, 8'h00);
    bus(1'b0, OFF_RES_LOW, 8'h00, {res[1:0], 6'h00});
    bus(1'b0, OFF_RES_HIGH, 8'h00, res[9:2]);
    bus(1'b1, OFF_CHAN, 8'h00, 8'h00);
    bus(1'b1, OFF_CTRL_A, 8'h98, 8'h00);
    bus(1'b0, OFF_CTRL_A, 8'h00, 8'h88);
    wait_irq(1'b0, 4);
    bus(1'b0, OFF_RES_LOW, 8'h00, res[7:0]);
    seed = lfsr(seed);
    core_val <= seed[9:0];
    bus(1'b1, OFF_CTRL_A, 8'hc8, 8'h00);
    wait_irq(1'b1, 2000);
    bus(1'b0, OFF_RES_HIGH, 8'h00, {6'h00, res[9:8]});
    kick(9);
    wait_irq(1'b0, 4);
    bus(1'b1, OFF_CTRL_A, 8'hc0, 8'h00);
    wait_irq(1'b0, 200);
    bus(1'b0, OFF_CTRL_A, 8'h00, 8'h90);
    bus(1'b1, OFF_CTRL_A, 8'h98, 8'h00);
    wait_irq(1'b0, 4);
    res = seed[9:0];
    bus(1'b1, OFF_CTRL_A, 8'hc8, 8'h00);
    repeat (6) @(posedge clk_sys);
    bus(1'b1, OFF_CTRL_A, 8'h08, 8'h00);
    wait_irq(1'b1, 2000);
    bus(1'b0, OFF_CTRL_A, 8'h00, 8'h18);
    bus(1'b1, OFF_CTRL_A, 8'h98, 8'h00);
    for (int c = 1; c < 9; c++)
    begin
      bus(1'b1, OFF_CTRL_B, 8'h80 | 8'(c), 8'h00);
      bus(1'b1, OFF_CTRL_A, 8'ha8, 8'h00);
      kick(c);
      wait_irq(1'b1, 2000);
      bus(1'b1, OFF_CTRL_A, 8'hb8, 8'h00);
    end
    bus(1'b1, OFF_CTRL_B, 8'h95, 8'h00);
    kick(5);
    wait_irq(1'b1, 2000);
    bus(1'b1, OFF_CTRL_A, 8'hb8, 8'h00);
    kick(5);
    wait_irq(1'b0, 200);
    bus(1'b0, OFF_RES_HIGH, 8'h00, {6'h00, res[9:8]});
    kick(5);
    wait_irq(1'b1, 2000);
    bus(1'b1, OFF_CTRL_A, 8'h98, 8'h00);
    kick(5);
    wait_irq(1'b0, 200);
    bus(1'b1, OFF_CTRL_B, 8'hc0, 8'h00);
    kick(10);
    wait_irq(1'b0, 200);
    bus(1'b1, OFF_CTRL_B, 8'h80, 8'h00);
    kick(10);
    wait_irq(1'b1, 2000);
    bus(1'b1, OFF_CTRL_A, 8'h98, 8'h00);
    bus(1'b1, OFF_CHAN, {4'h0, CHAN_AMP}, 8'h00);
    // divide by 128 keeps the internal sync clock near 122kHz
    bus(1'b1, OFF_CTRL_A, 8'hcf, 8'h00);
    disturb <= 1'b1;
    repeat (4) @(posedge clk_sys);
    disturb <= 1'b0;
    wait_irq(1'b1, 4000);
    bus(1'b0, OFF_RES_LOW, 8'h00, res[7:0]);
    bus(1'b0, OFF_RES_HIGH, 8'h00, {6'h00, res[9:8]});
    chk(32'(chan), 32'(CHAN_AMP));
    // amplified auto trigger on a stage event: the trigger only arms, the next stage event starts
    bus(1'b1, OFF_AMP, 8'h01, 8'h00);
    bus(1'b1, OFF_CTRL_B, 8'h85, 8'h00);
    bus(1'b1, OFF_CTRL_A, 8'hbf, 8'h00);
    kick(5);
    wait_irq(1'b0, 600);
    kick(5);
    wait_irq(1'b1, 4000);
    test_done();
  end
endmodule
`default_nettype wire

// ---- acc_core_model.sv ----
// behavioural analog core and amplifier seen from the converter control block
// assumes the bench sets the sample value before a conversion starts
`timescale 1ns/1ns
`default_nettype none
module acc_core_model
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       converting,
  input  wire logic       core_sample,
  input  wire logic [9:0] sample_value,
  input  wire logic       disturb,
  output logic      [9:0] core_result,
  output logic            amp_out_changed
);
  logic       live_reg;
  logic [9:0] held_reg;

  // result stays valid one cycle past the end so the capture edge is covered
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      live_reg <= 1'b0;
    else
      live_reg <= converting;

  // value taken at conversion start and on each amplifier sampling event
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      held_reg <= 10'h000;
    else if (core_sample || (converting && !live_reg))
      held_reg <= sample_value;

  // outside the valid window the line shows the inverse, never a stale copy
  assign core_result = (converting || live_reg) ? held_reg : ~held_reg;
  // the amplifier output moves only when the bench commands a disturbance
  assign amp_out_changed = disturb && converting;
endmodule
`default_nettype wire

// ---- acc_pkg.sv ----
// package for the converter control block: register map, field positions, timing
// assumes a classic wishbone slave with 32-bit data, one register per aligned word
package acc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL_A   = 8'h00;
  localparam logic [7:0] OFF_CTRL_B   = 8'h04;
  localparam logic [7:0] OFF_RES_LOW  = 8'h08;
  localparam logic [7:0] OFF_RES_HIGH = 8'h0c;
  localparam logic [7:0] OFF_DIS_0    = 8'h10;
  localparam logic [7:0] OFF_DIS_1    = 8'h14;
  localparam logic [7:0] OFF_CHAN     = 8'h18;
  localparam logic [7:0] OFF_AMP      = 8'h1c;

  // control a fields
  localparam int A_ENABLE  = 7;
  localparam int A_START   = 6;
  localparam int A_AUTO    = 5;
  localparam int A_FLAG    = 4;
  localparam int A_IRQ_EN  = 3;
  // control b fields
  localparam int B_HSPEED  = 7;
  localparam int B_NOSLEEP = 6;
  localparam int B_SINGLE  = 4;
  // channel register fields
  localparam int CH_LEFT   = 5;

  // reset values
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_DIS    = 8'h00;
  localparam logic [7:0] RST_CHAN   = 8'h00;
  localparam logic [7:0] RST_AMP    = 8'h00;

  // amplified channel code and trigger codes
  localparam logic [3:0] CHAN_AMP    = 4'hb;
  localparam logic [3:0] TRG_FREE    = 4'h0;
  localparam logic [3:0] TRG_STAGE_R = 4'h5;
  localparam logic [3:0] TRG_STAGE_2 = 4'h6;
  localparam logic [3:0] TRG_LAST    = 4'h8;
  localparam logic [1:0] AMP_TRG_DIV = 2'h0;
  localparam logic [1:0] AMP_TRG_R   = 2'h1;
  localparam logic [1:0] AMP_TRG_2   = 2'h3;

  // conversion timing in converter clock cycles
  localparam int CONV_CYCLES      = 13;
  localparam int CONV_CYCLES_SYNC = 14;
  localparam int AMP_DIV          = 8;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } acc_state_type;

  // bus request carrier
  typedef struct packed
  {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [7:0] adr;
    logic [7:0] dat;
  } acc_bus_req_type;

endpackage
